// ==== soi_dev_end.sv ====
// soi_dev_end.sv: core end, overhead insertion, parity and scrambling of one lane
// assumes frame words arrive on aclk from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module soi_dev_end
   import soi_pkg::*;
#(
   parameter int LANE_ID = 0
) (
   input wire logic aclk,
   input wire logic aresetn,
   soi_link_if.dev link,
   output logic [31:0] line_word,
   output logic line_frame_pulse
);
   // ----------------------------------------------------------------
   // input stage and frame position
   // ----------------------------------------------------------------
   logic [31:0] word_reg;
   logic sof_reg;
   logic [10:0] wpos_reg;
   logic [3:0] row_reg;
   logic [3:0] w12_reg;
   logic [7:0] b1_reg;
   logic [7:0] b1_acc_reg;
   logic [6:0] scr_reg;
   logic [7:0] b2_acc_reg [0:STS_N-1];
   logic [7:0] b2_frame_reg [0:STS_N-1];
   logic [31:0] ins_word;
   logic [31:0] scr_word;
   logic [31:0] key_word;
   logic [6:0] scr_next;
   logic in_toh;
   logic line_area;
   logic row0_toh;
   logic [1:0] col;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_reg <= '0;
         sof_reg <= 1'b0;
      end else begin
         word_reg <= link.tx_frame_word;
         sof_reg <= link.tx_frame_pulse;
      end
   end

   // the pulse realigns the counters at any time, so a slipped frame recovers at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wpos_reg <= '0;
         row_reg <= '0;
         w12_reg <= '0;
      end else if (link.tx_frame_pulse) begin
         wpos_reg <= '0;
         row_reg <= '0;
         w12_reg <= '0;
      end else begin
         if (w12_reg == W12_LAST) begin
            w12_reg <= '0;
         end else begin
            w12_reg <= w12_reg + 4'h1;
         end
         if (wpos_reg == ROW_LAST) begin
            wpos_reg <= '0;
            if (row_reg == ROW_COUNT_LAST) begin
               row_reg <= '0;
            end else begin
               row_reg <= row_reg + 4'h1;
            end
         end else begin
            wpos_reg <= wpos_reg + 11'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // overhead byte selection
   // ----------------------------------------------------------------
   function automatic logic [7:0] ovh_byte(
      input soi_mode_type m,
      input logic fr_en,
      input logic pa_en,
      input logic rdi,
      input logic [3:0] row,
      input logic [1:0] cl,
      input logic first,
      input logic [7:0] b1,
      input logic [7:0] b2,
      input logic [7:0] din
   );
      logic [7:0] v;
      v = din;
      if (m == SOI_FULL_OVERHEAD_INSERT_MODE) begin
         // growth, sync status and remote error bytes stay zero here
         v = OVH_ZERO;
         case (row)
            ROW_FRAMING: begin
               if (cl == COL_A) v = FRAMING_FIRST;
               if (cl == COL_B) v = FRAMING_SECOND;
            end
            ROW_SECTION_PARITY: begin
               if (cl == COL_A && first) v = b1;
               if (cl == COL_C && first) v = 8'(LANE_ID + 1);
            end
            ROW_POINTER: begin
               if (cl == COL_A) v = first ? PTR_HI_FIRST : PTR_HI_OTHER;
               if (cl == COL_B) v = first ? PTR_LO_FIRST : PTR_LO_OTHER;
               // pointer action byte: no justification is ever made here
               if (cl == COL_C) v = OVH_ZERO;
            end
            ROW_LINE_PARITY: begin
               if (cl == COL_A) v = b2;
               if (cl == COL_C && first && rdi) v = APS_RDI;
            end
            default: v = OVH_ZERO;
         endcase
      end else if (m == SOI_SECTION_OVERHEAD_INSERT_MODE) begin
         if (row == ROW_FRAMING && fr_en) begin
            if (cl == COL_A) v = FRAMING_FIRST;
            if (cl == COL_B) v = FRAMING_SECOND;
         end
         if (row == ROW_SECTION_PARITY && cl == COL_A && pa_en) begin
            v = first ? b1 : OVH_ZERO;
         end
         if (row == ROW_LINE_PARITY && cl == COL_C && first && rdi) begin
            v = APS_RDI;
         end
      end
      return v;
   endfunction

   always_comb begin
      logic [5:0] sts;
      sts = '0;
      in_toh = (wpos_reg < TOH_END);
      line_area = !(in_toh && row_reg < ROW_LINE_START);
      row0_toh = in_toh && (row_reg == ROW_FRAMING);
      if (wpos_reg < COL_B_START) begin
         col = COL_A;
      end else if (wpos_reg < COL_C_START) begin
         col = COL_B;
      end else begin
         col = COL_C;
      end
      ins_word = word_reg;
      if (in_toh) begin
         for (int l = 0; l < WORD_BYTES; l++) begin
            sts = {w12_reg, 2'(l)};
            ins_word[WORD_W-1-BYTE_W*l -: BYTE_W] = ovh_byte(
               link.mode, link.framing_en, link.parity_en, link.force_rdi,
               row_reg, col, (sts == 6'h00), b1_reg, b2_frame_reg[sts],
               word_reg[WORD_W-1-BYTE_W*l -: BYTE_W]);
         end
      end
   end

   // ----------------------------------------------------------------
   // line parity, one accumulator per sts-1
   // ----------------------------------------------------------------
   for (genvar i = 0; i < STS_N; i++) begin : g_line_parity
      localparam logic [3:0] WSEL = 4'(i / WORD_BYTES);
      localparam int LSEL = i % WORD_BYTES;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            b2_acc_reg[i] <= '0;
            b2_frame_reg[i] <= '0;
         end else if (sof_reg) begin
            b2_frame_reg[i] <= b2_acc_reg[i];
            b2_acc_reg[i] <= '0;
         end else if (line_area && w12_reg == WSEL) begin
            // taken before the scrambler, section overhead skipped
            b2_acc_reg[i] <= b2_acc_reg[i] ^ ins_word[WORD_W-1-BYTE_W*LSEL -: BYTE_W];
         end
      end
   end

   // ----------------------------------------------------------------
   // scrambler and section parity
   // ----------------------------------------------------------------
   function automatic logic [38:0] scr_run(input logic [6:0] seed);
      logic [6:0] s;
      logic [31:0] k;
      s = seed;
      k = '0;
      for (int i = 0; i < WORD_W; i++) begin
         k[WORD_W-1-i] = s[SCR_W-1];
         s = {s[SCR_W-2:0], s[SCR_W-1] ^ s[SCR_W-2]};
      end
      return {s, k};
   endfunction

   function automatic logic [7:0] fold(input logic [31:0] w);
      return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
   endfunction

   always_comb begin
      {scr_next, key_word} = scr_run(scr_reg);
      // the first overhead row is never scrambled so the far framer can lock
      if (link.scramble_en && !row0_toh) begin
         scr_word = ins_word ^ key_word;
      end else begin
         scr_word = ins_word;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scr_reg <= SCR_SEED;
      end else if (row0_toh) begin
         scr_reg <= SCR_SEED;
      end else begin
         scr_reg <= scr_next;
      end
   end

   // the first frame after reset sends a parity built from a partial frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b1_acc_reg <= '0;
         b1_reg <= '0;
      end else if (sof_reg) begin
         b1_reg <= b1_acc_reg;
         b1_acc_reg <= fold(scr_word);
      end else begin
         b1_acc_reg <= b1_acc_reg ^ fold(scr_word);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_word <= '0;
         line_frame_pulse <= 1'b0;
      end else begin
         line_word <= scr_word;
         line_frame_pulse <= sof_reg;
      end
   end
endmodule : soi_dev_end
`default_nettype wire

// ==== soi_host_end.sv ====
// soi_host_end.sv: logic end, frame word source with axi4-lite control registers
// assumes software on an axi4-lite master clocked by aclk
`timescale 1ns/1ps
`default_nettype none
module soi_host_end
   import soi_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   soi_link_if.host link
);
   logic [31:0] ctrl_reg;
   logic [31:0] frames_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wstrb_reg;
   logic [10:0] gpos_reg;
   logic [3:0] grow_reg;
   logic [31:0] pat_reg;

   // ----------------------------------------------------------------
   // axi4-lite write
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrl_reg <= CTRL_RESET;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got_reg && !s_axi_bvalid;
         s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_got_reg && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb[0];
         end
         if (aw_got_reg && w_got_reg) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg == REG_CTRL) begin
               if (wstrb_reg) ctrl_reg <= wdata_reg & CTRL_MASK;
               s_axi_bresp <= RESP_OKAY;
            end else if (awaddr_reg == REG_STATUS) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == REG_CTRL) begin
               s_axi_rdata <= ctrl_reg;
               s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr == REG_STATUS) begin
               s_axi_rdata <= frames_reg;
               s_axi_rresp <= RESP_OKAY;
            end else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame word source
   // ----------------------------------------------------------------
   // stopping mid-frame is allowed; the next start resends a full frame from word 0
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_reg[CTRL_RUN]) begin
         gpos_reg <= '0;
         grow_reg <= '0;
         pat_reg <= '0;
         frames_reg <= frames_reg;
         link.tx_frame_pulse <= 1'b0;
         link.tx_frame_word <= '0;
         if (!aresetn) frames_reg <= '0;
      end else begin
         link.tx_frame_pulse <= (gpos_reg == '0) && (grow_reg == '0);
         link.tx_frame_word <= pat_reg;
         pat_reg <= pat_reg + 32'h0000_0001;
         if (gpos_reg == ROW_LAST) begin
            gpos_reg <= '0;
            if (grow_reg == ROW_COUNT_LAST) begin
               grow_reg <= '0;
               frames_reg <= frames_reg + 32'h0000_0001;
            end else begin
               grow_reg <= grow_reg + 4'h1;
            end
         end else begin
            gpos_reg <= gpos_reg + 11'h001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.mode <= SOI_TRANSPARENT_MODE;
         link.framing_en <= 1'b0;
         link.parity_en <= 1'b0;
         link.scramble_en <= 1'b0;
         link.force_rdi <= 1'b0;
      end else begin
         link.mode <= soi_mode_type'(ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO]);
         link.framing_en <= ctrl_reg[CTRL_FRAMING];
         link.parity_en <= ctrl_reg[CTRL_PARITY];
         link.scramble_en <= ctrl_reg[CTRL_SCRAMBLE];
         link.force_rdi <= ctrl_reg[CTRL_RDI];
      end
   end
endmodule : soi_host_end
`default_nettype wire

// ==== soi_link_if.sv ====
// soi_link_if.sv: frame word link plus overhead controls from the logic to the core
// assumes both ends run on the same aclk
`timescale 1ns/1ps
`default_nettype none
interface soi_link_if;
   import soi_pkg::*;
   logic [31:0] tx_frame_word;
   logic tx_frame_pulse;
   soi_mode_type mode;
   logic framing_en;
   logic parity_en;
   logic scramble_en;
   logic force_rdi;
   modport host (
      output tx_frame_word,
      output tx_frame_pulse,
      output mode,
      output framing_en,
      output parity_en,
      output scramble_en,
      output force_rdi
   );
   modport dev (
      input tx_frame_word,
      input tx_frame_pulse,
      input mode,
      input framing_en,
      input parity_en,
      input scramble_en,
      input force_rdi
   );
endinterface : soi_link_if
`default_nettype wire

// ==== soi_link_sva.sv ====
// soi_link_sva.sv: assertions on the overhead link and the core's line output
// assumes one aclk; instantiated by the bench beside the link interface
`timescale 1ns/1ps
`default_nettype none
module soi_link_sva
   import soi_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] tx_frame_word,
   input wire logic tx_frame_pulse,
   input wire soi_mode_type mode,
   input wire logic framing_en,
   input wire logic parity_en,
   input wire logic scramble_en,
   input wire logic [31:0] line_word,
   input wire logic line_frame_pulse
);
   logic [31:0] din_d1_reg, din_d2_reg;
   logic [4:0] cfg, cfg_d1_reg, cfg_d2_reg;
   logic [10:0] wd, word_reg;
   logic [3:0] rw, row_reg;
   logic ok, ok_reg, st, tr, sec, full;
   // controls must hold three cycles so a frame word never straddles a change
   assign cfg = {mode, framing_en, parity_en, scramble_en};
   assign ok = line_frame_pulse | ok_reg;
   assign st = ok && cfg == cfg_d1_reg && cfg == cfg_d2_reg && !scramble_en;
   assign tr = st && !sec && !full;
   assign sec = st && mode == SOI_SECTION_OVERHEAD_INSERT_MODE;
   assign full = st && mode == SOI_FULL_OVERHEAD_INSERT_MODE;
   assign wd = line_frame_pulse ? 11'h000 : word_reg;
   assign rw = line_frame_pulse ? 4'h0 : row_reg;
   always_ff @(posedge aclk) begin
      din_d1_reg <= tx_frame_word;
      din_d2_reg <= din_d1_reg;
      cfg_d1_reg <= cfg;
      cfg_d2_reg <= cfg_d1_reg;
   end
   // position of the word now on line_word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ok_reg <= 1'b0;
         word_reg <= 11'h000;
         row_reg <= 4'h0;
      end else begin
         ok_reg <= ok;
         word_reg <= (wd == ROW_LAST) ? 11'h000 : wd + 11'h001;
         if (wd == ROW_LAST) begin
            row_reg <= (rw == ROW_COUNT_LAST) ? 4'h0 : rw + 4'h1;
         end else begin
            row_reg <= rw;
         end
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_pulse_delay;
      tx_frame_pulse |-> ##2 line_frame_pulse;
   endproperty
   a_pulse_delay: assert property (p_pulse_delay) else $error("frame pulse lost");
   property p_pulse_gap;
      line_frame_pulse |=> !line_frame_pulse [*8];
   endproperty
   a_pulse_gap: assert property (p_pulse_gap) else $error("frame pulse repeated");
   property p_transp;
      tr |-> line_word == din_d2_reg;
   endproperty
   a_transp: assert property (p_transp) else $error("transparent word altered");
   property p_framing;
      sec && framing_en && rw == ROW_FRAMING && wd < COL_B_START |-> line_word == 32'hF6F6F6F6;
   endproperty
   a_framing: assert property (p_framing) else $error("first framing byte wrong");
   property p_framing2;
      sec && framing_en && rw == ROW_FRAMING && wd >= COL_B_START && wd < COL_C_START
         |-> line_word == 32'h28282828;
   endproperty
   a_framing2: assert property (p_framing2) else $error("second framing byte wrong");
   property p_framing_off;
      sec && !framing_en && rw == ROW_FRAMING && wd < TOH_END |-> line_word == din_d2_reg;
   endproperty
   a_framing_off: assert property (p_framing_off) else $error("framing inserted");
   property p_parity_zero;
      sec && parity_en && rw == ROW_SECTION_PARITY && wd < COL_B_START
         |-> line_word[23:0] == 24'h0 && (wd == 11'h000 || line_word[31:24] == 8'h00);
   endproperty
   a_parity_zero: assert property (p_parity_zero) else $error("parity byte nonzero");
   property p_full_zero;
      full && rw == 4'h2 && wd < TOH_END |-> line_word == 32'h0;
   endproperty
   a_full_zero: assert property (p_full_zero) else $error("data channel nonzero");
   property p_pointer;
      full && rw == ROW_POINTER && wd < COL_B_START |-> line_word[23:0] == 24'h939393;
   endproperty
   a_pointer: assert property (p_pointer) else $error("pointer byte wrong");
   property p_payload;
      st && wd >= TOH_END |-> line_word == $past(tx_frame_word, 2);
   endproperty
   a_payload: assert property (p_payload) else $error("payload word altered");
   property p_sec_pass;
      sec && rw > ROW_LINE_PARITY && wd < TOH_END |-> line_word == din_d2_reg;
   endproperty
   a_sec_pass: assert property (p_sec_pass) else $error("overhead not passed");
   c_framing: cover property (sec && framing_en && rw == ROW_FRAMING && wd == 11'h000);
   c_pointer: cover property (full && rw == ROW_POINTER && wd == 11'h000);
   c_transp: cover property (tr && wd == TOH_END);
endmodule : soi_link_sva
`default_nettype wire

// ==== soi_pkg.sv ====
// soi_pkg.sv: constants and types shared by both ends of the sts-48 overhead link
// assumes one transmit clock for both ends; byte lane 0 is bits 31:24 and leaves first
package soi_pkg;
   typedef enum logic [1:0] {
      SOI_TRANSPARENT_MODE = 2'h0,
      SOI_SECTION_OVERHEAD_INSERT_MODE = 2'h1,
      SOI_FULL_OVERHEAD_INSERT_MODE = 2'h2
   } soi_mode_type;

   // ----------------------------------------------------------------
   // frame geometry
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int BYTE_W = 8;
   localparam int WORD_BYTES = 4;
   localparam int STS_N = 48;
   localparam int ROWS = 9;
   localparam int TOH_WORDS = 36;
   localparam int SPE_WORDS = 1044;
   localparam int COL_WORDS = 12;
   localparam logic [10:0] ROW_LAST = 11'(TOH_WORDS + SPE_WORDS - 1);
   localparam logic [10:0] TOH_END = 11'(TOH_WORDS);
   localparam logic [10:0] COL_B_START = 11'(COL_WORDS);
   localparam logic [10:0] COL_C_START = 11'(2 * COL_WORDS);
   localparam logic [3:0] ROW_COUNT_LAST = 4'(ROWS - 1);
   localparam logic [3:0] W12_LAST = 4'(COL_WORDS - 1);
   localparam logic [3:0] ROW_FRAMING = 4'h0;
   localparam logic [3:0] ROW_SECTION_PARITY = 4'h1;
   localparam logic [3:0] ROW_LINE_START = 4'h3;
   localparam logic [3:0] ROW_POINTER = 4'h3;
   localparam logic [3:0] ROW_LINE_PARITY = 4'h4;
   localparam logic [1:0] COL_A = 2'h0;
   localparam logic [1:0] COL_B = 2'h1;
   localparam logic [1:0] COL_C = 2'h2;

   // ----------------------------------------------------------------
   // overhead byte values
   // ----------------------------------------------------------------
   localparam logic [7:0] FRAMING_FIRST = 8'hF6;
   localparam logic [7:0] FRAMING_SECOND = 8'h28;
   localparam logic [7:0] PTR_HI_FIRST = 8'h62;
   localparam logic [7:0] PTR_LO_FIRST = 8'h0A;
   localparam logic [7:0] PTR_HI_OTHER = 8'h93;
   localparam logic [7:0] PTR_LO_OTHER = 8'hFF;
   localparam logic [7:0] APS_RDI = 8'h06;
   localparam logic [7:0] OVH_ZERO = 8'h00;
   localparam int SCR_W = 7;
   localparam logic [6:0] SCR_SEED = 7'h7F;

   // ----------------------------------------------------------------
   // controller registers
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_MODE_LO = 1;
   localparam int CTRL_MODE_HI = 2;
   localparam int CTRL_FRAMING = 3;
   localparam int CTRL_PARITY = 4;
   localparam int CTRL_SCRAMBLE = 5;
   localparam int CTRL_RDI = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0038;
   localparam logic [31:0] CTRL_MASK = 32'h0000_007F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : soi_pkg

// ==== test_sonet_overhead_insertion.sv ====
// test_sonet_overhead_insertion.sv: bench joining the logic end and the core end
// assumes package, link interface and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module test_sonet_overhead_insertion
   import soi_pkg::*;
;
   localparam int LANE = 2;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, line_frame_pulse;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, line_word, din_q1, din_q2, din_exp, sp_acc, sp_ref, lp_acc, lp_ref;
   int o_row, o_word;
   int n_mismatch = 0, tests_run = 0;
   soi_link_if link ();
   always #25 aclk = ~aclk;
   soi_host_end u_soi_host_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link.host));
   soi_dev_end #(.LANE_ID(LANE)) u_soi_dev_end (.aclk(aclk), .aresetn(aresetn),
      .link(link.dev), .line_word(line_word), .line_frame_pulse(line_frame_pulse));
   soi_link_sva u_soi_link_sva (.aclk(aclk), .aresetn(aresetn),
      .tx_frame_word(link.tx_frame_word), .tx_frame_pulse(link.tx_frame_pulse),
      .mode(link.mode), .framing_en(link.framing_en), .parity_en(link.parity_en),
      .scramble_en(link.scramble_en), .line_word(line_word),
      .line_frame_pulse(line_frame_pulse));
   // ----
   // line monitor: position and two-cycle-old input word
   // ----
   always @(posedge aclk) begin
      #1;
      if (line_frame_pulse === 1'b1) begin
         o_row = 0;
         o_word = 0;
         sp_ref = {sp_acc[31:24] ^ sp_acc[23:16] ^ sp_acc[15:8] ^ sp_acc[7:0], 24'h0};
         lp_ref = lp_acc;
         sp_acc = '0;
         lp_acc = '0;
      end else if (o_word == 1079) begin
         o_word = 0;
         o_row = (o_row == 8) ? 0 : o_row + 1;
      end else begin
         o_word++;
      end
      sp_acc ^= line_word;
      if (o_word % 12 == 0 && (o_row > 2 || o_word > 35)) lp_acc ^= line_word;
      din_exp = din_q2;
      din_q2 = din_q1;
      din_q1 = link.tx_frame_word;
   end
   function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [3:0] en);
      return {25'h0, en, m, 1'b1};
   endfunction : ctrl
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", bresp, er)
   endtask : axi_write
   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK("rdata", rdata, ed)
      `CHK("rresp", rresp, er)
   endtask : axi_read
   // the first frame after a control change is mixed, so wait for the next one
   task automatic sync_frame();
      repeat (4) @(posedge aclk);
      do begin
         @(posedge aclk);
         #2;
      end while (line_frame_pulse !== 1'b1);
   endtask : sync_frame
   task automatic expect_at(input int r, w, input logic [31:0] m, f, x);
      while (!(o_row == r && o_word == w)) begin
         @(posedge aclk);
         #2;
      end
      `CHK("line_word", line_word, ((din_exp ^ x) & ~m) | (f & m))
   endtask : expect_at
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   // ----
   // tests
   // ----
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(REG_CTRL, CTRL_RESET, RESP_OKAY);
      axi_read(REG_STATUS, 32'h0, RESP_OKAY);
      axi_read(4'h8, 32'h0, RESP_SLVERR);
      axi_write(4'hC, 32'h7F, RESP_SLVERR);
      axi_write(REG_STATUS, 32'h5, RESP_OKAY);
      axi_read(REG_STATUS, 32'h0, RESP_OKAY);
      axi_read(REG_CTRL, CTRL_RESET, RESP_OKAY);
      $display("test registers done");
      axi_write(REG_CTRL, ctrl(2'h0, 4'h0), RESP_OKAY);
      sync_frame();
      expect_at(0, 0, '0, '0, '0);
      expect_at(0, 12, '0, '0, '0);
      expect_at(1, 0, '0, '0, '0);
      expect_at(4, 24, '0, '0, '0);
      expect_at(5, 100, '0, '0, '0);
      $display("test transparent done");
      axi_write(REG_CTRL, ctrl(2'h1, 4'b0001), RESP_OKAY);
      sync_frame();
      expect_at(0, 0, '1, 32'hF6F6F6F6, '0);
      expect_at(0, 12, '1, 32'h28282828, '0);
      expect_at(0, 24, '0, '0, '0);
      expect_at(1, 0, '0, '0, '0);
      expect_at(3, 0, '0, '0, '0);
      expect_at(4, 0, '0, '0, '0);
      $display("test section framing done");
      axi_write(REG_CTRL, ctrl(2'h1, 4'b1010), RESP_OKAY);
      sync_frame();
      expect_at(0, 0, '0, '0, '0);
      expect_at(1, 0, '1, sp_ref, '0);
      expect_at(1, 5, '1, '0, '0);
      expect_at(4, 24, 32'hFF000000, 32'h06000000, '0);
      expect_at(4, 25, '0, '0, '0);
      $display("test section parity done");
      axi_write(REG_CTRL, ctrl(2'h2, 4'b0011), RESP_OKAY);
      sync_frame();
      expect_at(0, 0, '1, 32'hF6F6F6F6, '0);
      expect_at(0, 24, '1, '0, '0);
      expect_at(1, 12, '1, '0, '0);
      expect_at(1, 24, '1, {8'(LANE + 1), 24'h0}, '0);
      expect_at(2, 0, '1, '0, '0);
      expect_at(3, 0, '1, 32'h62939393, '0);
      expect_at(3, 12, '1, 32'h0AFFFFFF, '0);
      expect_at(3, 24, '1, '0, '0);
      expect_at(4, 0, '1, lp_ref, '0);
      expect_at(4, 24, '1, '0, '0);
      expect_at(5, 36, '0, '0, '0);
      expect_at(8, 35, '1, '0, '0);
      $display("test full insert done");
      axi_write(REG_CTRL, ctrl(2'h2, 4'b1111), RESP_OKAY);
      sync_frame();
      expect_at(0, 0, '1, 32'hF6F6F6F6, '0);
      expect_at(0, 36, '0, '0, 32'hFE041851);
      $display("test scrambler done");
      close_out();
   end
   initial begin
      repeat (90000) @(posedge aclk);
      n_mismatch++;
      $display("watchdog expired");
      close_out();
   end
endmodule : test_sonet_overhead_insertion
`default_nettype wire
